// ### ilidpc_pkg.sv
`default_nettype none

package ilidpc_pkg;

    // ==========================================================
    // Geometry
    // ==========================================================
    localparam int LINES = 32;
    localparam int ADDR_W = 8;

    // ==========================================================
    // Register byte offsets (one aligned 32-bit word each)
    // ==========================================================
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OFS_IRQ_DISABLE = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_OD_ENABLE = 8'h10;
    localparam logic [7:0] OFS_OD_DISABLE = 8'h14;
    localparam logic [7:0] OFS_OD_STATE = 8'h18;
    localparam logic [7:0] OFS_PU_DISABLE = 8'h1c;
    localparam logic [7:0] OFS_PU_ENABLE = 8'h20;
    localparam logic [7:0] OFS_PU_STATE = 8'h24;
    localparam logic [7:0] OFS_FUNC_A_SEL = 8'h28;
    localparam logic [7:0] OFS_FUNC_B_SEL = 8'h2c;
    localparam logic [7:0] OFS_FUNC_AB_STATE = 8'h30;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_STATUS = 32'h0000_0000;
    localparam logic [31:0] RST_OD_STATE = 32'h0000_0000;
    localparam logic [31:0] RST_PU_OFF = 32'h0000_0000;
    localparam logic [31:0] RST_FUNC_B = 32'h0000_0000;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // ==========================================================
    // Bus answers
    // ==========================================================
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [3:0] {
        REG_IRQ_ENABLE = 4'h0,
        REG_IRQ_DISABLE = 4'h1,
        REG_IRQ_MASK = 4'h2,
        REG_IRQ_STATUS = 4'h3,
        REG_OD_ENABLE = 4'h4,
        REG_OD_DISABLE = 4'h5,
        REG_OD_STATE = 4'h6,
        REG_PU_DISABLE = 4'h7,
        REG_PU_ENABLE = 4'h8,
        REG_PU_STATE = 4'h9,
        REG_FUNC_A_SEL = 4'ha,
        REG_FUNC_B_SEL = 4'hb,
        REG_FUNC_AB_STATE = 4'hc,
        REG_NONE = 4'hf
    } ilidpc_reg_type;

    // One source of pad drive: value and enable per line
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] en;
    } ilidpc_drive_type;

endpackage

`default_nettype wire

// ### ilidpc_ctrl.sv
// Functional notes
// R1 - All registers 32 bits, bit n is line n
// R2 - Mask register reads 1 for enabled interrupts
// R3 - Status bit sets on line level change
// R4 - Reading status clears all its bits
// R5 - Open-drain enable writes set per line
// R6 - Open-drain disable writes clear per line
// R7 - Open-drain off: drive both levels, reads 0
// R8 - Open-drain on: drive low only, reads 1
// R9 - Pull-up disable writes turn pull-up off
// R10 - Pull-up enable writes turn pull-up on
// R11 - Pull-up state reads inverted: 0 means on
// R12 - Function A select routes line to A
// R13 - Interrupt enable writes set mask bits
// R14 - Interrupt disable writes clear mask bits
// R15 - Function state reads 0 A, 1 B
// R16 - Function B select routes line to B
// R17 - Interrupt high while status and mask set
// R18 - Change is current versus previous sample
`timescale 1ns/100ps
`default_nettype none

module ilidpc_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive sources from the rest of the controller and the peripherals
    input wire logic [31:0] line_owned,
    input wire ilidpc_pkg::ilidpc_drive_type gpio_drive,
    input wire ilidpc_pkg::ilidpc_drive_type func_a_drive,
    input wire ilidpc_pkg::ilidpc_drive_type func_b_drive,
    // Pads
    input wire logic [31:0] pad_in,
    output logic [31:0] pad_out,
    output logic [31:0] pad_oe,
    output logic [31:0] pad_pullup_en,
    // Sampled levels and function routing
    output logic [31:0] line_level,
    output logic [31:0] func_b_routed,
    // Interrupt
    output logic irq
);

    // ==========================================================
    // Address decode, shared by read and write paths
    // ==========================================================
    function automatic ilidpc_pkg::ilidpc_reg_type decode_reg(input logic [7:0] addr);
        logic [7:0] word;
        // Byte lanes share a word
        word = {addr[7:2], 2'b00};
        case (word)
            ilidpc_pkg::OFS_IRQ_ENABLE: decode_reg = ilidpc_pkg::REG_IRQ_ENABLE;
            ilidpc_pkg::OFS_IRQ_DISABLE: decode_reg = ilidpc_pkg::REG_IRQ_DISABLE;
            ilidpc_pkg::OFS_IRQ_MASK: decode_reg = ilidpc_pkg::REG_IRQ_MASK;
            ilidpc_pkg::OFS_IRQ_STATUS: decode_reg = ilidpc_pkg::REG_IRQ_STATUS;
            ilidpc_pkg::OFS_OD_ENABLE: decode_reg = ilidpc_pkg::REG_OD_ENABLE;
            ilidpc_pkg::OFS_OD_DISABLE: decode_reg = ilidpc_pkg::REG_OD_DISABLE;
            ilidpc_pkg::OFS_OD_STATE: decode_reg = ilidpc_pkg::REG_OD_STATE;
            ilidpc_pkg::OFS_PU_DISABLE: decode_reg = ilidpc_pkg::REG_PU_DISABLE;
            ilidpc_pkg::OFS_PU_ENABLE: decode_reg = ilidpc_pkg::REG_PU_ENABLE;
            ilidpc_pkg::OFS_PU_STATE: decode_reg = ilidpc_pkg::REG_PU_STATE;
            ilidpc_pkg::OFS_FUNC_A_SEL: decode_reg = ilidpc_pkg::REG_FUNC_A_SEL;
            ilidpc_pkg::OFS_FUNC_B_SEL: decode_reg = ilidpc_pkg::REG_FUNC_B_SEL;
            ilidpc_pkg::OFS_FUNC_AB_STATE: decode_reg = ilidpc_pkg::REG_FUNC_AB_STATE;
            default: decode_reg = ilidpc_pkg::REG_NONE;
        endcase
    endfunction

    // ==========================================================
    // Declarations
    // ==========================================================
    // Bus channels
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // Register state
    logic [31:0] irq_mask_q;
    logic [31:0] irq_status_q;
    logic [31:0] od_state_q;
    logic [31:0] pu_off_q;
    logic [31:0] func_b_q;

    // Pads and interrupt
    logic [31:0] level_q;
    logic [31:0] level_prev_q;
    logic sample_ok_q;
    logic [31:0] pad_out_q;
    logic [31:0] pad_oe_q;
    logic irq_q;

    // Decoded signals
    logic wr_fire;
    logic rd_fire;
    ilidpc_pkg::ilidpc_reg_type wr_reg;
    ilidpc_pkg::ilidpc_reg_type rd_reg;
    logic [31:0] wr_bits;
    logic [31:0] change;
    logic [31:0] status_rd_clr;
    logic [31:0] status_wr_clr;
    logic [31:0] drv_data;
    logic [31:0] drv_en;
    logic [31:0] rd_value;

    // ==========================================================
    // Write channel: address and data taken in either order
    // ==========================================================
    // Ready while free
    assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready = ~w_hold_q & ~bvalid_q;
    // Both halves held: the write acts on this edge and the answer rises
    assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
    assign wr_reg = decode_reg(aw_addr_q);

    // Byte strobes gate which lines a write touches
    generate
        for (genvar b = 0; b < 4; b++) begin : g_strb
            assign wr_bits[8*b +: 8] = w_strb_q[b] ? w_data_q[8*b +: 8] : 8'h00; // see R1
        end
    endgenerate

    // Capture write address
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
        end
    end

    // Capture write data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            w_hold_q <= 1'b0;
            w_data_q <= ilidpc_pkg::RST_ZERO;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_q <= 1'b0;
        end
    end

    // Write response, held until the master takes it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= ilidpc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_reg == ilidpc_pkg::REG_NONE) ? ilidpc_pkg::RESP_DECERR : ilidpc_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Answer outputs
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ==========================================================
    // Read channel: one read in flight, data registered
    // ==========================================================
    // Ready when idle
    assign s_axi_arready = ~rvalid_q;
    assign rd_fire = s_axi_arvalid & ~rvalid_q;
    assign rd_reg = decode_reg(s_axi_araddr);

    // Read mux; write-only registers read as zero
    always_comb begin
        case (rd_reg)
            ilidpc_pkg::REG_IRQ_MASK: rd_value = irq_mask_q; // see R2
            ilidpc_pkg::REG_IRQ_STATUS: rd_value = irq_status_q; // see R3
            ilidpc_pkg::REG_OD_STATE: rd_value = od_state_q; // see R7 see R8
            ilidpc_pkg::REG_PU_STATE: rd_value = pu_off_q; // see R11
            ilidpc_pkg::REG_FUNC_AB_STATE: rd_value = func_b_q; // see R15
            default: rd_value = ilidpc_pkg::RST_ZERO;
        endcase
    end

    // Read answer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rresp_q <= ilidpc_pkg::RESP_OKAY;
            rdata_q <= ilidpc_pkg::RST_ZERO;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_value;
            rresp_q <= (rd_reg == ilidpc_pkg::REG_NONE) ? ilidpc_pkg::RESP_DECERR : ilidpc_pkg::RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Answer outputs
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ==========================================================
    // Interrupt enable and mask
    // ==========================================================
    // Enable and disable in one write cannot collide: they are separate words
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_mask_q <= ilidpc_pkg::RST_IRQ_MASK;
        end else if (wr_fire && wr_reg == ilidpc_pkg::REG_IRQ_ENABLE) begin
            irq_mask_q <= irq_mask_q | wr_bits; // see R13
        end else if (wr_fire && wr_reg == ilidpc_pkg::REG_IRQ_DISABLE) begin
            irq_mask_q <= irq_mask_q & ~wr_bits; // see R14
        end
    end

    // ==========================================================
    // Pin sampling and change detection
    // ==========================================================
    // The first sample after reset has no predecessor, so it raises no change
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            level_q <= ilidpc_pkg::RST_ZERO;
            level_prev_q <= ilidpc_pkg::RST_ZERO;
            sample_ok_q <= 1'b0;
        end else begin
            level_q <= pad_in;
            level_prev_q <= sample_ok_q ? level_q : pad_in; // see R18
            sample_ok_q <= 1'b1;
        end
    end

    // Edge of either polarity
    assign change = sample_ok_q ? (level_q ^ level_prev_q) : ilidpc_pkg::RST_ZERO; // see R18

    // Levels for the controller
    assign line_level = level_q;

    // ==========================================================
    // Interrupt status: read clears, write of one also clears
    // ==========================================================
    // Clear masks
    assign status_rd_clr = (rd_fire && rd_reg == ilidpc_pkg::REG_IRQ_STATUS) ? 32'hffff_ffff : 32'h0000_0000;
    assign status_wr_clr = (wr_fire && wr_reg == ilidpc_pkg::REG_IRQ_STATUS) ? wr_bits : 32'h0000_0000;

    // A change in the clearing cycle survives: set wins over clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_status_q <= ilidpc_pkg::RST_IRQ_STATUS;
        end else begin
            irq_status_q <= (irq_status_q & ~status_rd_clr & ~status_wr_clr) | change; // see R3 see R4
        end
    end

    // Level interrupt from a flip-flop, one cycle behind the status
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_mask_q); // see R17
        end
    end

    // Interrupt output
    assign irq = irq_q;

    // ==========================================================
    // Open-drain, pull-up and function select state
    // ==========================================================
    // Multi-drive state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            od_state_q <= ilidpc_pkg::RST_OD_STATE;
        end else if (wr_fire && wr_reg == ilidpc_pkg::REG_OD_ENABLE) begin
            od_state_q <= od_state_q | wr_bits; // see R5
        end else if (wr_fire && wr_reg == ilidpc_pkg::REG_OD_DISABLE) begin
            od_state_q <= od_state_q & ~wr_bits; // see R6
        end
    end

    // Stored inverted so the state register reads straight out
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pu_off_q <= ilidpc_pkg::RST_PU_OFF;
        end else if (wr_fire && wr_reg == ilidpc_pkg::REG_PU_DISABLE) begin
            pu_off_q <= pu_off_q | wr_bits; // see R9
        end else if (wr_fire && wr_reg == ilidpc_pkg::REG_PU_ENABLE) begin
            pu_off_q <= pu_off_q & ~wr_bits; // see R10
        end
    end

    // Pull-up on when not off
    assign pad_pullup_en = ~pu_off_q; // see R11

    // 0 selects A, 1 selects B
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            func_b_q <= ilidpc_pkg::RST_FUNC_B;
        end else if (wr_fire && wr_reg == ilidpc_pkg::REG_FUNC_A_SEL) begin
            func_b_q <= func_b_q & ~wr_bits; // see R12
        end else if (wr_fire && wr_reg == ilidpc_pkg::REG_FUNC_B_SEL) begin
            func_b_q <= func_b_q | wr_bits; // see R16
        end
    end

    // Routing to the pad mux
    assign func_b_routed = func_b_q;

    // ==========================================================
    // Output stage
    // ==========================================================
    // Owned lines take the controller's drive, others the selected function
    assign drv_data = (line_owned & gpio_drive.data)
        | (~line_owned & ~func_b_q & func_a_drive.data)
        | (~line_owned & func_b_q & func_b_drive.data); // see R12 see R16

    // Enables follow the same routing
    assign drv_en = (line_owned & gpio_drive.en)
        | (~line_owned & ~func_b_q & func_a_drive.en)
        | (~line_owned & func_b_q & func_b_drive.en);

    // Open-drain lines only pull low; a high is a release to the pull-up
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pad_out_q <= ilidpc_pkg::RST_ZERO;
            pad_oe_q <= ilidpc_pkg::RST_ZERO;
        end else begin
            pad_out_q <= drv_data & ~od_state_q; // see R7 see R8
            pad_oe_q <= drv_en & (~od_state_q | ~drv_data); // see R7 see R8
        end
    end

    // Registered pad outputs
    assign pad_out = pad_out_q;
    assign pad_oe = pad_oe_q;

endmodule // ilidpc_ctrl

`default_nettype wire

// ### ilidpc_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module ilidpc_ctrl_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads and interrupt
    input wire logic [31:0] pad_in,
    input wire logic [31:0] pad_oe,
    input wire logic [31:0] pad_pullup_en,
    input wire logic [31:0] line_level,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ==========================================================
    // Bus handshakes
    // ==========================================================
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted while a response is pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered one cycle after address taken");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released after it was taken");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read response not released after it was taken");

    // ==========================================================
    // Lines, pull-ups and interrupt
    // ==========================================================
    a_level_follow: assert property ($past(rst) == 1'b0 |-> line_level == $past(pad_in))
        else $error("line level is not the pad sampled one cycle earlier");
    // A quiet line during a status read must leave the interrupt low two cycles on
    a_read_clears_irq: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == ilidpc_pkg::OFS_IRQ_STATUS && line_level == $past(line_level) |-> ##2 !irq)
        else $error("interrupt still high after status was read");
    // Pull-up controls move only with a completed register write
    a_pullup_write: assert property ($changed(pad_pullup_en) |-> $rose(s_axi_bvalid))
        else $error("pull-up control changed without a register write");
    a_reset_state: assert property (disable iff (1'b0) rst |=>
        pad_pullup_en == 32'hffff_ffff && pad_oe == 32'h0 && !irq)
        else $error("pads or interrupt not at reset state after reset");
endmodule // ilidpc_ctrl_asserts

`default_nettype wire

// ### ilidpc_pads.sv
`timescale 1ns/100ps
`default_nettype none

module ilidpc_pads (
    // Clock
    input wire logic clk_sys,
    // Device drive
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    input wire logic [31:0] pad_pullup_en,
    // Outside parties that can only pull low
    input wire logic [31:0] ext_low,
    // Resolved level
    output logic [31:0] pad_in
);
    logic [31:0] float_q = 32'h0;

    // A released line with no pull-up wanders, so a stale level is never trusted
    always_ff @(posedge clk_sys) begin
        float_q <= ~float_q;
    end

    // Device drive wins, then a low pull, then the pull-up, else floating
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~ext_low & (pad_pullup_en | float_q));
endmodule // ilidpc_pads

`default_nettype wire

// ### ilidpc_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none

module ilidpc_ctrl_bench;
    // ==========================================================
    // Signals
    // ==========================================================
    localparam logic [1:0] OK = ilidpc_pkg::RESP_OKAY;
    localparam logic [1:0] DE = ilidpc_pkg::RESP_DECERR;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, pad_in, pad_out, pad_oe, pad_pullup_en, line_level, func_b_routed;
    logic [31:0] line_owned = 32'hffff_ffff, ext_low = 32'h0;
    ilidpc_pkg::ilidpc_drive_type gpio_drive = 64'h0, func_a_drive = 64'h0, func_b_drive = 64'h0;
    int miscompares = 0;
    int n_compared = 0;

    // Free-running 25 MHz clock
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    ilidpc_ctrl DUT (.clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_owned(line_owned),
        .gpio_drive(gpio_drive), .func_a_drive(func_a_drive), .func_b_drive(func_b_drive),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
        .line_level(line_level), .func_b_routed(func_b_routed), .irq(irq));

    ilidpc_pads u_pads (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup_en(pad_pullup_en), .ext_low(ext_low), .pad_in(pad_in));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Both write channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (aw_done && w_done && s_axi_bvalid) break;
            if (s_axi_awready && !aw_done) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_done) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
    endtask

    // Read data is only meaningful on an OKAY answer
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_done;
        ar_done = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (ar_done && s_axi_rvalid) break;
            if (s_axi_arready && !ar_done) begin
                ar_done = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
        if (er === OK) chk("rdata", s_axi_rdata, ed);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
    endtask

    task automatic end_sim;
        $display("compared %0d, miscompared %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        end_sim;
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset state, write-only word, unmapped word
        rd(ilidpc_pkg::OFS_IRQ_MASK, 32'h0, OK);
        rd(ilidpc_pkg::OFS_IRQ_STATUS, 32'h0, OK);
        rd(ilidpc_pkg::OFS_OD_STATE, 32'h0, OK);
        rd(ilidpc_pkg::OFS_PU_STATE, 32'h0, OK);
        rd(ilidpc_pkg::OFS_FUNC_AB_STATE, 32'h0, OK);
        rd(ilidpc_pkg::OFS_OD_ENABLE, 32'h0, OK);
        rd(8'h40, 32'h0, DE);
        wr(8'h40, 32'hffff_ffff, DE);
        $display("test reset done");
        // Mask set and clear, change flags, read clearing
        wr(ilidpc_pkg::OFS_IRQ_ENABLE, 32'h0000_00ff, OK);
        wr(ilidpc_pkg::OFS_IRQ_DISABLE, 32'h0000_00f0, OK);
        rd(ilidpc_pkg::OFS_IRQ_MASK, 32'h0000_000f, OK);
        ext_low <= 32'h0000_0101;
        repeat (4) @(posedge clk_sys);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(ilidpc_pkg::OFS_IRQ_STATUS, 32'h0000_0101, OK);
        repeat (2) @(posedge clk_sys);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(ilidpc_pkg::OFS_IRQ_STATUS, 32'h0, OK);
        ext_low <= 32'h0000_0001;
        repeat (4) @(posedge clk_sys);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(ilidpc_pkg::OFS_IRQ_STATUS, 32'h0000_0100, OK);
        $display("test irq done");
        // Open drain on line 5 only; state word ignores writes
        wr(ilidpc_pkg::OFS_OD_ENABLE, 32'h0000_0030, OK);
        wr(ilidpc_pkg::OFS_OD_DISABLE, 32'h0000_0010, OK);
        wr(ilidpc_pkg::OFS_OD_STATE, 32'hffff_ffff, OK);
        rd(ilidpc_pkg::OFS_OD_STATE, 32'h0000_0020, OK);
        gpio_drive <= {32'h0000_0030, 32'h0000_0030};
        repeat (3) @(posedge clk_sys);
        chk("pad_oe", pad_oe, 32'h0000_0010);
        chk("pad_out", pad_out, 32'h0000_0010);
        gpio_drive <= {32'h0, 32'h0000_0030};
        repeat (3) @(posedge clk_sys);
        chk("pad_oe", pad_oe, 32'h0000_0030);
        chk("pad_out", pad_out, 32'h0);
        $display("test open drain done");
        // Pull-ups off on lines 0 and 2, line 0 back on
        ext_low <= 32'h0000_0005;
        wr(ilidpc_pkg::OFS_PU_DISABLE, 32'h0000_0005, OK);
        rd(ilidpc_pkg::OFS_PU_STATE, 32'h0000_0005, OK);
        wr(ilidpc_pkg::OFS_PU_ENABLE, 32'h0000_0001, OK);
        rd(ilidpc_pkg::OFS_PU_STATE, 32'h0000_0004, OK);
        chk("pad_pullup_en", pad_pullup_en, 32'hffff_fffb);
        $display("test pull-up done");
        // Function B on lines 2 and 3, line 2 back to A
        wr(ilidpc_pkg::OFS_FUNC_B_SEL, 32'h0000_000c, OK);
        rd(ilidpc_pkg::OFS_FUNC_AB_STATE, 32'h0000_000c, OK);
        wr(ilidpc_pkg::OFS_FUNC_A_SEL, 32'h0000_0004, OK);
        rd(ilidpc_pkg::OFS_FUNC_AB_STATE, 32'h0000_0008, OK);
        line_owned <= 32'hffff_fff3;
        func_a_drive <= {32'h4, 32'hc};
        func_b_drive <= {32'h8, 32'hc};
        repeat (2) @(posedge clk_sys);
        chk("func_b_routed", func_b_routed, 32'h0000_0008);
        chk("pad_out", pad_out, 32'hc);
        $display("test functions done");
        end_sim;
    end
endmodule // ilidpc_ctrl_bench

bind ilidpc_ctrl ilidpc_ctrl_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pad_in(pad_in), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .line_level(line_level), .irq(irq));

`default_nettype wire
